// ===== rtl/qpt_pkg.sv
// Purpose: constants and types for one timer subsystem (PWM / capture).
// Assumes: 16-bit register port, word index addressing, 50 MHz system clock.
// Notes:   constants used by the timer core and its checks.
// ============================================================================
// Overview of operation
// - dual mode splits counter into two bytes
// - prescaler runs; counter steps on prescale match
// - period match clears counter on next step
// - pin starts default, flips on 0 to 1
// - duty match returns pin to default
// - duty above period gives full duty
// - zero duty keeps pin at default
// - period and duty double buffered while running
// - reads return last software written value
// - counter writes only while both stopped
// - preset counter keeps pin default until wrap
// - preset above period counts to ff first (ffff in 16-bit mode)
// - stop: pin default, counter holds, load buffers
// - prescaler reset when both stopped or on capture reset
// - 16-bit mode uses lower run bit only
// - 16-bit mode drives both pins, own polarity
// - capture copies counter into period or duty
// - lower run bit starts capture counting
// - capture edge select, optional counter reset
// - low power freezes, blocks data writes
// - low power blocks pending flag clears
// - four pending flags with enables, one request
// - pending flag sources per mode
// - mode field encodes four operations
// - three-bit capture edge field encoding
// - write one clears a pending flag
package qpt_pkg;
    // ========================================================================
    // register map (word index)
    localparam logic [2:0] ADDR_MODE   = 3'h0; // mode field, go bits
    localparam logic [2:0] ADDR_PINCTL = 3'h1; // edge fields, polarity bits
    localparam logic [2:0] ADDR_PRESC  = 3'h2; // prescale match field
    localparam logic [2:0] ADDR_COUNT  = 3'h3; // tick value
    localparam logic [2:0] ADDR_PERIOD = 3'h4; // period / capture
    localparam logic [2:0] ADDR_DUTY   = 3'h5; // duty / capture
    localparam logic [2:0] ADDR_IRQEN  = 3'h6; // interrupt enables
    localparam logic [2:0] ADDR_IRQPND = 3'h7; // pending flags, write one clears
    // ========================================================================
    // field positions
    localparam int MODE_LSB   = 0;  // two-bit subsystem mode field
    localparam int GO_LO_BIT  = 2;
    localparam int GO_HI_BIT  = 3;
    localparam int EDGE0_LSB  = 0;  // three-bit capture edge field, pin 0
    localparam int POL0_BIT   = 3;
    localparam int EDGE1_LSB  = 4;
    localparam int POL1_BIT   = 7;
    localparam int FLAG_A     = 0;
    localparam int FLAG_B     = 1;
    localparam int FLAG_C     = 2;
    localparam int FLAG_D     = 3;
    // ========================================================================
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [3:0]  RST_NIB  = 4'h0;
    localparam logic [7:0]  LANE_ONE = 8'h01; // count value after the 0 to 1 step
    localparam logic [15:0] CNT_ONE  = 16'h0001;
    localparam logic [15:0] CNT_TOP  = 16'hffff;
    // ========================================================================
    // subsystem modes
    typedef enum logic [1:0] {
        MODE_LOWPWR  = 2'b00,
        MODE_DUAL8   = 2'b01,
        MODE_PWM16   = 2'b10,
        MODE_CAPTURE = 2'b11
    } qpt_mode_t;
endpackage

// ===== rtl/qpt_timer.sv
// Purpose: one timer subsystem: dual 8-bit PWM, 16-bit PWM, dual capture.
// Assumes: inputs synchronous to clk; read data valid one cycle after rd.
// Notes:   unmapped reads return zero; all outputs come from flip-flops.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module qpt_timer (
    input  wire logic        clk,           // 50 MHz system clock
    input  wire logic        reset_n,       // async active-low reset
    input  wire logic [2:0]  reg_addr,      // register word index
    input  wire logic [15:0] reg_wdata,     // write data
    input  wire logic        reg_wr,        // write strobe
    input  wire logic        reg_rd,        // read strobe
    output logic      [15:0] reg_rdata,     // read data, cycle after rd
    input  wire logic [1:0]  timer_pin_in,  // pin levels for capture
    output logic      [1:0]  timer_pin_out, // PWM pin levels
    output logic      [1:0]  timer_pin_oe,  // high while pins driven
    output logic             irq            // subsystem interrupt request
);
    // ========================================================================
    // reset release
    logic rst_meta_ff;
    logic rst_n_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ========================================================================
    // state
    qpt_pkg::qpt_mode_t mode_ff, nxt_mode;
    logic [1:0]  go_ff, nxt_go;
    logic [7:0]  pinctl_ff, nxt_pinctl;
    logic [7:0]  presc_ff, nxt_presc;
    logic [7:0]  psc_ff, nxt_psc;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] per_sw_ff, nxt_per_sw;
    logic [15:0] duty_sw_ff, nxt_duty_sw;
    logic [15:0] per_act_ff, nxt_per_act;
    logic [15:0] duty_act_ff, nxt_duty_act;
    logic [1:0]  state_ff, nxt_state;   // 1 = pin away from default
    logic [3:0]  en_ff, nxt_en;
    logic [3:0]  pend_ff, nxt_pend;
    logic [1:0]  prev_in_ff;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [1:0]  pin_ff, nxt_pin;
    logic [1:0]  oe_ff, nxt_oe;
    logic        irq_ff, nxt_irq;

    // ========================================================================
    // decode helpers
    // capture strobe for one pin given its edge field
    function automatic logic cap_hit(input logic [2:0] e, input logic r, input logic f);
        cap_hit = e[2] ? (r | f) : (e[0] ? f : r);
    endfunction

    // counter reset strobe for one pin given its edge field
    function automatic logic cap_clr(input logic [2:0] e, input logic r, input logic f);
        if (!e[2]) begin
            cap_clr = e[1] & (e[0] ? f : r);
        end else begin
            cap_clr = (e[0] & r) | (e[1] & f);
        end
    endfunction

    // ========================================================================
    // combinational status
    logic        lowpwr;
    logic        run0;
    logic        run1;
    logic        any_run;
    logic        tick;
    logic [1:0]  rise;
    logic [1:0]  fall;
    logic [1:0]  cap_ev;
    logic        cap_rst;
    logic [2:0]  edge0;
    logic [2:0]  edge1;

    // run bits per mode; upper go bit only counts in dual mode
    always_comb begin
        lowpwr  = (mode_ff == qpt_pkg::MODE_LOWPWR);
        run0    = go_ff[0] & !lowpwr;
        run1    = go_ff[1] & (mode_ff == qpt_pkg::MODE_DUAL8);
        any_run = run0 | run1;
        tick    = any_run & (psc_ff == presc_ff);
        edge0   = pinctl_ff[qpt_pkg::EDGE0_LSB +: 3];
        edge1   = pinctl_ff[qpt_pkg::EDGE1_LSB +: 3];
        rise    = timer_pin_in & ~prev_in_ff;
        fall    = ~timer_pin_in & prev_in_ff;
        // captures only while the lower go bit runs the counter
        cap_ev[0] = (mode_ff == qpt_pkg::MODE_CAPTURE) & run0
                    & cap_hit(edge0, rise[0], fall[0]);
        cap_ev[1] = (mode_ff == qpt_pkg::MODE_CAPTURE) & run0
                    & cap_hit(edge1, rise[1], fall[1]);
        cap_rst   = (mode_ff == qpt_pkg::MODE_CAPTURE) & run0
                    & (cap_clr(edge0, rise[0], fall[0]) | cap_clr(edge1, rise[1], fall[1]));
    end

    // ========================================================================
    // next state of all registers but pins, request and read data
    logic        wr_cfg;
    logic [3:0]  ev;
    logic [7:0]  c8;
    logic [7:0]  p8;
    logic [7:0]  d8;
    logic [7:0]  n8;
    always_comb begin
        nxt_mode     = mode_ff;
        nxt_go       = go_ff;
        nxt_pinctl   = pinctl_ff;
        nxt_presc    = presc_ff;
        nxt_psc      = psc_ff;
        nxt_cnt      = cnt_ff;
        nxt_per_sw   = per_sw_ff;
        nxt_duty_sw  = duty_sw_ff;
        nxt_per_act  = per_act_ff;
        nxt_duty_act = duty_act_ff;
        nxt_state    = state_ff;
        nxt_en       = en_ff;
        nxt_pend     = pend_ff;
        ev           = qpt_pkg::RST_NIB;
        wr_cfg       = reg_wr;
        c8           = qpt_pkg::RST_BYTE;
        p8           = qpt_pkg::RST_BYTE;
        d8           = qpt_pkg::RST_BYTE;
        n8           = qpt_pkg::RST_BYTE;

        // prescaler: frozen in low power, cleared when nothing runs, on match and on capture reset
        if (!lowpwr) begin
            if (!any_run || cap_rst || tick) begin
                nxt_psc = qpt_pkg::RST_BYTE;
            end else begin
                nxt_psc = psc_ff + 8'h01;
            end
        end

        unique case (mode_ff)
            qpt_pkg::MODE_DUAL8: begin
                // two byte lanes, each its own counter and waveform
                for (int i = 0; i < 2; i++) begin
                    c8 = cnt_ff[8*i +: 8];
                    p8 = per_act_ff[8*i +: 8];
                    d8 = duty_act_ff[8*i +: 8];
                    if ((i == 0) ? run0 : run1) begin
                        if (tick) begin
                            n8 = (c8 == p8) ? qpt_pkg::RST_BYTE : c8 + 8'h01;
                            nxt_cnt[8*i +: 8] = n8;
                            if (c8 == p8) begin
                                ev[qpt_pkg::FLAG_B + 2*i] = 1'b1;
                                nxt_per_act[8*i +: 8]  = per_sw_ff[8*i +: 8];
                                nxt_duty_act[8*i +: 8] = duty_sw_ff[8*i +: 8];
                            end
                            if (c8 == d8) begin
                                ev[qpt_pkg::FLAG_A + 2*i] = 1'b1;
                            end
                            if (c8 == qpt_pkg::RST_BYTE && n8 == qpt_pkg::LANE_ONE) begin
                                nxt_state[i] = (d8 != qpt_pkg::RST_BYTE);
                            end else if (c8 == d8 && d8 <= p8) begin
                                nxt_state[i] = 1'b0;
                            end
                        end
                    end else begin
                        // stopped lane: default level, count held, buffers loaded
                        nxt_state[i] = 1'b0;
                        nxt_per_act[8*i +: 8]  = per_sw_ff[8*i +: 8];
                        nxt_duty_act[8*i +: 8] = duty_sw_ff[8*i +: 8];
                    end
                end
            end
            qpt_pkg::MODE_PWM16: begin
                if (run0) begin
                    if (tick) begin
                        nxt_cnt = (cnt_ff == per_act_ff) ? qpt_pkg::RST_WORD
                                                         : cnt_ff + 16'h0001;
                        if (cnt_ff == per_act_ff) begin
                            ev[qpt_pkg::FLAG_B] = 1'b1;
                            nxt_per_act  = per_sw_ff;
                            nxt_duty_act = duty_sw_ff;
                        end
                        if (cnt_ff == duty_act_ff) begin
                            ev[qpt_pkg::FLAG_A] = 1'b1;
                        end
                        if (cnt_ff == qpt_pkg::RST_WORD && nxt_cnt == qpt_pkg::CNT_ONE) begin
                            nxt_state[0] = (duty_act_ff != qpt_pkg::RST_WORD);
                        end else if (cnt_ff == duty_act_ff && duty_act_ff <= per_act_ff) begin
                            nxt_state[0] = 1'b0;
                        end
                    end
                end else begin
                    nxt_state[0] = 1'b0;
                    nxt_per_act  = per_sw_ff;
                    nxt_duty_act = duty_sw_ff;
                end
                nxt_state[1] = nxt_state[0];
            end
            qpt_pkg::MODE_CAPTURE: begin
                nxt_state = 2'b00;
                if (cap_rst) begin
                    nxt_cnt = qpt_pkg::RST_WORD;
                end else if (tick) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                    ev[qpt_pkg::FLAG_C] = (cnt_ff == qpt_pkg::CNT_TOP);
                end
                ev[qpt_pkg::FLAG_B] = cap_ev[0];
                ev[qpt_pkg::FLAG_A] = cap_ev[1];
            end
            qpt_pkg::MODE_LOWPWR: begin
                // everything frozen; configuration still writable
            end
        endcase

        // software writes; data registers are shut out in low power
        if (wr_cfg) begin
            unique case (reg_addr)
                qpt_pkg::ADDR_MODE: begin
                    nxt_mode = qpt_pkg::qpt_mode_t'(reg_wdata[qpt_pkg::MODE_LSB +: 2]);
                    nxt_go   = reg_wdata[qpt_pkg::GO_HI_BIT:qpt_pkg::GO_LO_BIT];
                end
                qpt_pkg::ADDR_PINCTL: nxt_pinctl = reg_wdata[7:0];
                qpt_pkg::ADDR_PRESC:  nxt_presc  = reg_wdata[7:0];
                qpt_pkg::ADDR_COUNT: begin
                    if (!lowpwr && !any_run) begin
                        nxt_cnt = reg_wdata;
                    end
                end
                qpt_pkg::ADDR_PERIOD: begin
                    if (!lowpwr) begin
                        nxt_per_sw = reg_wdata;
                    end
                end
                qpt_pkg::ADDR_DUTY: begin
                    if (!lowpwr) begin
                        nxt_duty_sw = reg_wdata;
                    end
                end
                qpt_pkg::ADDR_IRQEN: nxt_en = reg_wdata[3:0];
                qpt_pkg::ADDR_IRQPND: begin
                    if (!lowpwr) begin
                        nxt_pend = pend_ff & ~reg_wdata[3:0];
                    end
                end
            endcase
        end

        // a capture outranks a software write of the same register
        if (cap_ev[0]) begin
            nxt_per_sw = cnt_ff;
        end
        if (cap_ev[1]) begin
            nxt_duty_sw = cnt_ff;
        end

        // hardware set wins over a clear in the same cycle
        nxt_pend = nxt_pend | ev;
    end

    // ========================================================================
    // pin, request and read data next values
    always_comb begin
        nxt_irq   = |(nxt_pend & nxt_en);
        nxt_oe    = (mode_ff == qpt_pkg::MODE_DUAL8 || mode_ff == qpt_pkg::MODE_PWM16)
                    ? 2'b11 : 2'b00;
        nxt_pin   = pin_ff;
        if (!lowpwr) begin
            // low power keeps the last pin level so loads do not glitch
            nxt_pin[0] = pinctl_ff[qpt_pkg::POL0_BIT] ^ nxt_state[0];
            nxt_pin[1] = pinctl_ff[qpt_pkg::POL1_BIT] ^ nxt_state[1];
        end
        nxt_rdata = qpt_pkg::RST_WORD;
        if (reg_rd) begin
            unique case (reg_addr)
                qpt_pkg::ADDR_MODE:   nxt_rdata = {12'h000, go_ff, mode_ff};
                qpt_pkg::ADDR_PINCTL: nxt_rdata = {8'h00, pinctl_ff};
                qpt_pkg::ADDR_PRESC:  nxt_rdata = {8'h00, presc_ff};
                qpt_pkg::ADDR_COUNT:  nxt_rdata = cnt_ff;
                qpt_pkg::ADDR_PERIOD: nxt_rdata = per_sw_ff;
                qpt_pkg::ADDR_DUTY:   nxt_rdata = duty_sw_ff;
                qpt_pkg::ADDR_IRQEN:  nxt_rdata = {12'h000, en_ff};
                qpt_pkg::ADDR_IRQPND: nxt_rdata = {12'h000, pend_ff};
            endcase
        end
    end

    // ========================================================================
    // registers
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mode_ff     <= qpt_pkg::MODE_LOWPWR;
            go_ff       <= 2'b00;
            pinctl_ff   <= qpt_pkg::RST_BYTE;
            presc_ff    <= qpt_pkg::RST_BYTE;
            psc_ff      <= qpt_pkg::RST_BYTE;
            cnt_ff      <= qpt_pkg::RST_WORD;
            per_sw_ff   <= qpt_pkg::RST_WORD;
            duty_sw_ff  <= qpt_pkg::RST_WORD;
            per_act_ff  <= qpt_pkg::RST_WORD;
            duty_act_ff <= qpt_pkg::RST_WORD;
            state_ff    <= 2'b00;
            en_ff       <= qpt_pkg::RST_NIB;
            pend_ff     <= qpt_pkg::RST_NIB;
            prev_in_ff  <= 2'b00;
            rdata_ff    <= qpt_pkg::RST_WORD;
            pin_ff      <= 2'b00;
            oe_ff       <= 2'b00;
            irq_ff      <= 1'b0;
        end else begin
            mode_ff     <= nxt_mode;
            go_ff       <= nxt_go;
            pinctl_ff   <= nxt_pinctl;
            presc_ff    <= nxt_presc;
            psc_ff      <= nxt_psc;
            cnt_ff      <= nxt_cnt;
            per_sw_ff   <= nxt_per_sw;
            duty_sw_ff  <= nxt_duty_sw;
            per_act_ff  <= nxt_per_act;
            duty_act_ff <= nxt_duty_act;
            state_ff    <= nxt_state;
            en_ff       <= nxt_en;
            pend_ff     <= nxt_pend;
            prev_in_ff  <= timer_pin_in;
            rdata_ff    <= nxt_rdata;
            pin_ff      <= nxt_pin;
            oe_ff       <= nxt_oe;
            irq_ff      <= nxt_irq;
        end
    end

    // output drive
    assign reg_rdata     = rdata_ff;
    assign timer_pin_out = pin_ff;
    assign timer_pin_oe  = oe_ff;
    assign irq           = irq_ff;

    // ========================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_ff);

    logic is_dual;
    assign is_dual = (mode_ff == qpt_pkg::MODE_DUAL8);

    a_cnt_wr_blocked: assert property (
        (reg_wr && reg_addr == qpt_pkg::ADDR_COUNT && any_run && !tick && !cap_rst)
        |=> cnt_ff == $past(cnt_ff))
        else $error("counter written while running");
    a_psc_idle_clear: assert property (
        (!lowpwr && !any_run) |=> psc_ff == 8'h00)
        else $error("prescaler not cleared while idle");
    a_lowpwr_freeze: assert property (
        lowpwr |=> $stable(cnt_ff) && $stable(psc_ff))
        else $error("counter moved in low power");
    a_pend_kept_lp: assert property (
        lowpwr |=> (pend_ff & $past(pend_ff)) == $past(pend_ff))
        else $error("pending flag cleared in low power");
    a_irq_tracks: assert property (
        irq == |(pend_ff & en_ff))
        else $error("request does not follow enabled flags");
    a_stop_default: assert property (
        (is_dual && !go_ff[0]) |=> timer_pin_out[0] == $past(pinctl_ff[qpt_pkg::POL0_BIT]))
        else $error("stopped pin not at default level");
    a_period_wrap: assert property (
        (is_dual && run0 && tick && cnt_ff[7:0] == per_act_ff[7:0])
        |=> cnt_ff[7:0] == 8'h00 ##0 pend_ff[qpt_pkg::FLAG_B])
        else $error("period match did not clear counter");
    a_zero_duty: assert property (
        (is_dual && run0 && duty_act_ff[7:0] == 8'h00 && !state_ff[0]) |=> !state_ff[0])
        else $error("zero duty left default level");
    a_sw_readback: assert property (
        (reg_wr && reg_addr == qpt_pkg::ADDR_PERIOD && !lowpwr && !cap_ev[0])
        |=> per_sw_ff == $past(reg_wdata))
        else $error("period write not held for readback");
    a_cap_copy: assert property (
        cap_ev[0] |=> per_sw_ff == $past(cnt_ff) ##0 pend_ff[qpt_pkg::FLAG_B])
        else $error("capture did not copy counter");

    c_dual_period: cover property (is_dual && run0 && tick && cnt_ff[7:0] == per_act_ff[7:0]);
    c_pwm16_duty: cover property (mode_ff == qpt_pkg::MODE_PWM16 && tick
                                  && cnt_ff == duty_act_ff);
    c_capture_rst: cover property (cap_ev[1] && cap_rst);
endmodule

// ===== verification/qpt_pin_model.sv
// Purpose: far-side model of the two timer pins: loads and input sources.
// Assumes: tgl pulses come from the bench, one clock long.
// Notes:   no pull on the pins; an undriven pin shows the source level.
`timescale 1ns/1ps
module qpt_pin_model (
    input  wire logic       clk,     // system clock
    input  wire logic [1:0] tgl,     // flip the source level
    input  wire logic [1:0] pin_oe,  // design drives the pin
    input  wire logic [1:0] pin_out, // design pin level
    output logic      [1:0] pin_in   // resolved wire level
);
    logic [1:0] src_ff = 2'h0; // external source, starts low
    // source flips on command, so edge timing stays under bench control
    always_ff @(posedge clk) src_ff <= src_ff ^ tgl;
    // wire level: driver wins where enabled, else the source
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src_ff);
endmodule

// ===== verification/testbench.sv
// Purpose: self-checking bench for qpt_timer with a pin model.
// Assumes: 50 MHz clock; read data stands one cycle after the strobe.
// Notes:   the driver queues each expectation; a monitor checks them.
`timescale 1ns/1ps
`define CHK(v) begin comparisons++; e = eq.pop_front(); n = nq.pop_front(); \
 if ((v) !== e) begin failures++; $display("Error %s exp %h seen %h", n, e, v); end end
module testbench;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [1:0]  tgl = 2'h0;
    logic        rd_d = 1'b0;
    logic        rv = 1'b0;
    logic [15:0] res = 16'h0000;
    logic [15:0] s = 16'h0015;
    logic [15:0] reg_rdata, e, x;
    logic [1:0]  pin_in, pin_out, pin_oe;
    logic        irq;
    logic [15:0] eq[$];
    string       nq[$], n;
    int          failures = 0;
    int          comparisons = 0;
    always #10 clk = ~clk;
    qpt_timer DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_pin_in(pin_in),
        .timer_pin_out(pin_out), .timer_pin_oe(pin_oe), .irq(irq));
    qpt_pin_model pins (.clk(clk), .tgl(tgl), .pin_oe(pin_oe), .pin_out(pin_out),
        .pin_in(pin_in));
    // monitor: read data is looked at only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_d) `CHK(reg_rdata)
        if (rv) `CHK(res)
        rd_d <= reg_rd;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk) reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] d);
        eq.push_back(d);
        nq.push_back("reg");
        @(posedge clk) reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
    endtask
    task automatic put(input string t, input logic [15:0] d, input logic [15:0] r);
        eq.push_back(d);
        nq.push_back(t);
        @(posedge clk) res <= r;
        rv <= 1'b1;
        @(posedge clk) rv <= 1'b0;
    endtask
    // high cycles over ten whole periods, so the phase does not matter
    task automatic meas(input int i, input logic [15:0] d);
        x = 16'h0000;
        repeat (60) @(negedge clk) x = x + 16'(pin_out[i]);
        put("pin_high", d, x);
    endtask
    task automatic tg(input logic [1:0] t);
        @(posedge clk) tgl <= t;
        @(posedge clk) tgl <= 2'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // guard against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 8; a++) rd(3'(a), 16'h0000);
        $display("test reset done");
        wr(3'h2, 16'h0001);
        wr(3'h1, 16'h0080);
        wr(3'h0, 16'h0001); // leave low power (dual mode, stopped) so the period write is accepted
        wr(3'h4, 16'h0202);
        wr(3'h6, 16'h0001);
        wr(3'h0, 16'h000d);
        for (int d = 0; d < 4; d++) begin
            wr(3'h5, {2{8'(d)}});
            rd(3'h5, {2{8'(d)}});
            repeat (12) @(posedge clk);
            meas(0, (d > 2) ? 16'h003c : 16'(20 * d));
            meas(1, (d > 2) ? 16'h0000 : 16'(60 - 20 * d));
        end
        rd(3'h7, 16'h000f);
        put("irq", 16'h0001, 16'(irq));
        wr(3'h0, 16'h0001);
        repeat (3) @(posedge clk);
        put("pins", 16'h0002, 16'(pin_out));
        put("oe", 16'h0003, 16'(pin_oe));
        wr(3'h7, 16'h0001);
        rd(3'h7, 16'h000e);
        put("irq", 16'h0000, 16'(irq));
        wr(3'h3, 16'h0505);
        rd(3'h3, 16'h0505);
        $display("test dual pwm done");
        wr(3'h0, 16'h0000);
        wr(3'h7, 16'h000f);
        wr(3'h4, 16'h1111);
        rd(3'h7, 16'h000e);
        rd(3'h4, 16'h0202);
        rd(3'h3, 16'h0505);
        $display("test low power done");
        wr(3'h0, 16'h0001);
        wr(3'h5, 16'h0101);
        wr(3'h0, 16'h0005);
        meas(0, 16'h0000);
        repeat (480) @(posedge clk);
        meas(0, 16'h0014);
        wr(3'h0, 16'h0002);
        wr(3'h3, 16'h0000);
        wr(3'h4, 16'h0002);
        wr(3'h5, 16'h0001);
        wr(3'h0, 16'h0006);
        repeat (12) @(posedge clk);
        meas(0, 16'h0014);
        meas(1, 16'h0028);
        $display("test preset and 16-bit done");
        wr(3'h0, 16'h0003);
        wr(3'h7, 16'h000f);
        wr(3'h1, 16'h0010);
        tg(2'h1);
        rd(3'h7, 16'h0000);
        wr(3'h0, 16'h0007);
        tg(2'h3);
        rd(3'h7, 16'h0000);
        tg(2'h3);
        rd(3'h7, 16'h0003);
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            wr(3'h6, s);
            rd(3'h6, {12'h000, s[3:0]});
        end
        $display("test capture done");
        wr(3'h0, 16'h0003);
        wr(3'h2, 16'h00ff); // slow prescaler: no count step for 256 cycles
        wr(3'h3, 16'h0505);
        wr(3'h0, 16'h0007);
        wr(3'h3, 16'h1111);
        rd(3'h3, 16'h0505);
        wr(3'h1, 16'h0003);
        tg(2'h1);
        rd(3'h4, 16'h0505);
        rd(3'h3, 16'h0000);
        put("oe", 16'h0000, 16'(pin_oe));
        $display("test capture reset done");
        // let the last queued notes be checked before the verdict
        repeat (3) @(posedge clk);
        if (eq.size() != 0) failures++;
        test_done;
    end
endmodule
